//--- bench/tscr_regs_bench.sv
// Self-checking bench for the tag system configuration registers
`timescale 1ns/10ps
`include "tscr_map.svh"
module tscr_regs_bench import tscr_pkg::*;;
  logic clk_sys, resetn, i2c_rd, i2c_wr, system_area_select, i2c_password_ok, i2c_rvalid, rf_rvalid;
  logic i2c_cmd_active, i2c_write_active, wr_cycle_start, wr_cycle_ok, nvm_load, go, bad, wr, rdr_busy;
  logic read_config_cmd, write_harvest_cfg_cmd, write_pin_cfg_cmd, read_control_cmd, set_harvest_enable_cmd;
  logic rf_sof, rf_crc_done, rf_cmd_bad, rf_exec_done, rf_write_start, rf_answer_start;
  logic field_on_pin, harvest_power_ok_pin, harvest_load_ok_pin, rf_activity_pin_o, rf_activity_pin_oe;
  logic harvest_out_en, en, wr_done, s1, s2, bz, wp, m_b, m_w, m_c, exp_oe;
  logic [11:0] i2c_addr;
  logic [7:0]  i2c_wdata, i2c_rdata, nvm_config, rf_wdata, rf_rdata, config_byte, control_byte, cfg, lo, hi, d;
  logic [3:0]  sector_write_lock;
  int          num_errors, checked, i;

  tscr_regs uut (.*);
  tscr_rf_reader rdr (.*);

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_byte

  task cmp_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask : cmp_bit

  task give_verdict;
    $display("Errors %0d in %0d checks", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task wr8(input logic [11:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    {i2c_wr, i2c_addr, i2c_wdata} = {1'b1, a, v};
    @(negedge clk_sys);
    i2c_wr = 1'b0;
    if (system_area_select)
    begin
      if (a == `TSCR_ADDR_LOCK_LO && i2c_password_ok) lo = v;
      if (a == `TSCR_ADDR_LOCK_HI && i2c_password_ok) hi = v;
      if (a == `TSCR_ADDR_CONFIG) cfg = v;
      if (a == `TSCR_ADDR_CONTROL) en = v[0];
    end
  endtask : wr8

  task rd8(input logic [11:0] a);
    logic [7:0] e;
    e = !system_area_select ? 8'h00 : a == `TSCR_ADDR_LOCK_LO ? lo : a == `TSCR_ADDR_LOCK_HI ? hi :
        a == `TSCR_ADDR_CONFIG ? cfg : a == `TSCR_ADDR_CONTROL ? {wr_done, 5'h00, field_on_pin, en} : 8'h00;
    @(negedge clk_sys);
    {i2c_rd, i2c_addr} = {1'b1, a};
    @(negedge clk_sys);
    i2c_rd = 1'b0;
    cmp_bit("i2c_rvalid", 1'b1, i2c_rvalid);
    cmp_byte("i2c_rdata", e, i2c_rdata);
  endtask : rd8

  task rfc(input int k, input logic [7:0] v);
    @(negedge clk_sys);
    {set_harvest_enable_cmd, read_control_cmd, write_pin_cfg_cmd, write_harvest_cfg_cmd, read_config_cmd} = 5'h01 << k;
    rf_wdata = v;
    @(negedge clk_sys);
    {set_harvest_enable_cmd, read_control_cmd, write_pin_cfg_cmd, write_harvest_cfg_cmd, read_config_cmd} = 5'h00;
    if (k == 1) cfg[2:0] = v[2:0];
    if (k == 2) cfg[3] = v[3];
    if (k == 4) en = v[0];
    if (k == 0) cmp_byte("rf_rdata", cfg, rf_rdata);
    if (k == 3) cmp_byte("rf_rdata", {7'h01, en}, rf_rdata);
    if (k == 0 || k == 3) cmp_bit("rf_rvalid", 1'b1, rf_rvalid);
  endtask : rfc

  task frame(input logic b, input logic w);
    @(negedge clk_sys);
    {go, bad, wr} = {1'b1, b, w};
    @(negedge clk_sys);
    go = 1'b0;
    for (i = 0; i < 60 && rdr_busy; i++) @(negedge clk_sys);
    cmp_bit("frame end", 1'b0, rdr_busy);
  endtask : frame

  // Pin state from frame events; field loss forces release
  always @(posedge clk_sys or negedge resetn)
    if (!resetn)
      {s1, s2, bz, wp, m_b, m_w, m_c} <= 7'h00;
    else
    begin
      {s1, s2, m_b, m_w, m_c} <= {field_on_pin, s1, i2c_cmd_active, i2c_write_active, cfg[3]};
      bz <= s2 && (rf_sof || bz && !rf_exec_done && !(rf_crc_done && rf_cmd_bad));
      wp <= s2 && (rf_write_start || wp && !rf_answer_start && !rf_exec_done);
    end
  assign exp_oe = m_c ? wp && !m_w : bz && !m_b;
  always @(negedge clk_sys)
    if (resetn)
    begin
      cmp_bit("rf_activity_pin_oe", exp_oe, rf_activity_pin_oe);
      cmp_bit("rf_activity_pin_o", 1'b0, rf_activity_pin_o);
    end

  initial
  begin
    {i2c_rd, i2c_wr, i2c_cmd_active, i2c_write_active, wr_cycle_start, wr_cycle_ok, nvm_load, go, bad, wr} = 10'h000;
    {set_harvest_enable_cmd, read_control_cmd, write_pin_cfg_cmd, write_harvest_cfg_cmd, read_config_cmd} = 5'h00;
    {i2c_addr, i2c_wdata, nvm_config, rf_wdata, i2c_password_ok} = 37'h0;
    {system_area_select, field_on_pin, harvest_power_ok_pin, harvest_load_ok_pin} = 4'hF;
    {cfg, lo, hi, en, wr_done, num_errors, checked} = {`TSCR_CONFIG_RESET, 16'h0000, 1'b0, 1'b0, 64'h0};
    resetn = 1'b0;
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    void'($urandom(96839));
    repeat (3) @(negedge clk_sys);
    for (i = 0; i < 2; i++) rd8(`TSCR_ADDR_LOCK_LO + 12'(i));
    rd8(`TSCR_ADDR_CONFIG);
    rd8(`TSCR_ADDR_CONTROL);
    wr8(`TSCR_ADDR_LOCK_LO, 8'($urandom) | 8'h01);
    rd8(`TSCR_ADDR_LOCK_LO);
    i2c_password_ok = 1'b1;
    wr8(`TSCR_ADDR_LOCK_LO, 8'($urandom));
    wr8(`TSCR_ADDR_LOCK_HI, 8'($urandom));
    rd8(`TSCR_ADDR_LOCK_LO);
    rd8(`TSCR_ADDR_LOCK_HI);
    cmp_byte("sector_write_lock", {4'h0, lo[3:0]}, {4'h0, sector_write_lock});
    wr8(`TSCR_ADDR_LOCK_LO, 8'h00);
    rd8(`TSCR_ADDR_LOCK_LO);
    system_area_select = 1'b0;
    wr8(`TSCR_ADDR_CONFIG, 8'($urandom));
    rd8(`TSCR_ADDR_CONFIG);
    system_area_select = 1'b1;
    rd8(12'h7FF);
    wr8(`TSCR_ADDR_CONFIG, 8'($urandom));
    wr8(`TSCR_ADDR_CONTROL, 8'($urandom));
    rd8(`TSCR_ADDR_CONFIG);
    rd8(`TSCR_ADDR_CONTROL);
    for (int k = 0; k < 5; k++) rfc(k, 8'($urandom));
    rfc(0, 8'h00);
    rfc(3, 8'h00);
    cmp_byte("config_byte", cfg, config_byte);
    d = 8'($urandom);
    @(negedge clk_sys) {nvm_load, nvm_config} = {1'b1, d};
    @(negedge clk_sys) nvm_load = 1'b0;
    {cfg, en} = {d, !d[2]};
    rd8(`TSCR_ADDR_CONTROL);
    @(negedge clk_sys) wr_cycle_start = 1'b1;
    // Completion in the same cycle as a new start must win
    @(negedge clk_sys) {wr_cycle_start, wr_cycle_ok} = 2'h3;
    @(negedge clk_sys) {wr_cycle_start, wr_cycle_ok} = 2'h0;
    wr_done = 1'b1;
    rd8(`TSCR_ADDR_CONTROL);
    @(negedge clk_sys) wr_cycle_start = 1'b1;
    @(negedge clk_sys) wr_cycle_start = 1'b0;
    wr_done = 1'b0;
    rd8(`TSCR_ADDR_CONTROL);
    cmp_byte("control_byte", {wr_done, 5'h00, field_on_pin, en}, control_byte);
    for (int h = 0; h < 8; h++)
    begin
      wr8(`TSCR_ADDR_CONTROL, 8'(h));
      {harvest_load_ok_pin, harvest_power_ok_pin} = 2'(h >> 1);
      repeat (5) @(negedge clk_sys);
      cmp_bit("harvest_out_en", en && harvest_power_ok_pin && harvest_load_ok_pin, harvest_out_en);
    end
    field_on_pin = 1'b0;
    repeat (4) @(negedge clk_sys);
    rd8(`TSCR_ADDR_CONTROL);
    rfc(3, 8'h00);
    field_on_pin = 1'b1;
    rfc(2, 8'h00);
    repeat (4) @(negedge clk_sys);
    frame(1'b0, 1'b0);
    frame(1'b1, 1'b0);
    i2c_cmd_active = 1'b1;
    frame(1'b0, 1'b0);
    i2c_cmd_active = 1'b0;
    fork
      frame(1'b0, 1'b0);
      #200 field_on_pin = 1'b0;
    join
    field_on_pin = 1'b1;
    rfc(2, 8'h08);
    repeat (4) @(negedge clk_sys);
    frame(1'b0, 1'b1);
    i2c_write_active = 1'b1;
    frame(1'b0, 1'b1);
    i2c_write_active = 1'b0;
    give_verdict();
  end

  initial
  begin
    #400000;
    num_errors++;
    give_verdict();
  end
endmodule : tscr_regs_bench

bind tscr_regs tscr_regs_sva chk (.*);

//--- bench/tscr_regs_sva.sv
// Assertion checker for the tag system configuration registers
`timescale 1ns/10ps
module tscr_regs_sva (
  // Clock, reset and I2C side
  input wire logic        clk_sys, resetn, i2c_rd, i2c_wr, system_area_select, i2c_password_ok,
  input wire logic [11:0] i2c_addr,
  input wire logic        i2c_rvalid, i2c_cmd_active, i2c_write_active, wr_cycle_start, wr_cycle_ok,
  // RF side
  input wire logic        read_config_cmd, read_control_cmd, rf_rvalid, rf_sof, rf_crc_done, rf_cmd_bad,
  input wire logic        rf_exec_done, rf_write_start, rf_answer_start,
  input wire logic [7:0]  rf_rdata,
  // Pins and mirrors
  input wire logic        field_on_pin, harvest_power_ok_pin, harvest_load_ok_pin,
  input wire logic        rf_activity_pin_oe, harvest_out_en,
  input wire logic [3:0]  sector_write_lock,
  input wire logic [7:0]  config_byte, control_byte
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  chk_i2c_read_answer: assert property (i2c_rd |=> i2c_rvalid)
    else $error("I2C read not answered");
  chk_rf_read_answer: assert property (read_config_cmd || read_control_cmd |=> rf_rvalid)
    else $error("RF read not answered");
  chk_rf_control_view: assert property (read_control_cmd |=> rf_rdata[7:1] == 7'h01)
    else $error("RF view of control wrong");
  chk_lock_write_drop: assert property (i2c_wr && !i2c_password_ok && system_area_select
    && i2c_addr == 12'h800 |-> ##2 $stable(sector_write_lock))
    else $error("lock changed without password");
  chk_harvest_gate: assert property ((!harvest_power_ok_pin || !harvest_load_ok_pin) [*4]
    |-> !harvest_out_en)
    else $error("harvest on without power or load");
  chk_busy_start: assert property ((field_on_pin && !i2c_cmd_active) [*3]
    ##0 (rf_sof && !config_byte[3]) |=> rf_activity_pin_oe)
    else $error("busy pin not driven after frame start");
  chk_busy_end: assert property (!config_byte[3] && !rf_sof
    && (rf_exec_done || rf_crc_done && rf_cmd_bad) |=> !rf_activity_pin_oe)
    else $error("busy pin held after command end");
  chk_field_release: assert property ((!field_on_pin) [*3] |=> !rf_activity_pin_oe)
    else $error("pin driven without field");
  chk_i2c_mask: assert property ((config_byte[3] ? i2c_write_active : i2c_cmd_active)
    |=> !rf_activity_pin_oe)
    else $error("pin driven during I2C activity");
  chk_wip_start: assert property ((field_on_pin && !i2c_write_active) [*3]
    ##0 (config_byte[3] && rf_write_start) |=> rf_activity_pin_oe)
    else $error("write pin not driven");
  chk_wip_end: assert property (config_byte[3] && rf_answer_start |=> !rf_activity_pin_oe)
    else $error("write pin held after answer");
  chk_done_set: assert property (wr_cycle_ok |-> ##2 control_byte[7])
    else $error("write done flag not set");
  chk_done_clear: assert property (wr_cycle_start && !wr_cycle_ok |-> ##2 !control_byte[7])
    else $error("write done flag not cleared");
endmodule : tscr_regs_sva

//--- bench/tscr_rf_reader.sv
// RF reader model issuing command frames to the block
`timescale 1ns/10ps
module tscr_rf_reader (
  input wire logic clk_sys, go, bad, wr,
  output logic     rf_sof, rf_crc_done, rf_cmd_bad, rf_exec_done, rf_write_start, rf_answer_start, rdr_busy
);
  initial
  begin
    {rf_sof, rf_crc_done, rf_cmd_bad, rf_exec_done, rf_write_start, rf_answer_start, rdr_busy} = 7'h00;
    forever
    begin
      @(posedge clk_sys);
      if (go)
      begin
        rdr_busy = 1'b1;
        @(negedge clk_sys) rf_sof = 1'b1;
        @(negedge clk_sys) rf_sof = 1'b0;
        repeat (3) @(negedge clk_sys);
        // bad flag only qualifies the CRC cycle
        rf_crc_done = 1'b1;
        rf_cmd_bad = bad;
        @(negedge clk_sys) rf_crc_done = 1'b0;
        rf_cmd_bad = !bad;
        if (!bad)
        begin
          repeat (2) @(negedge clk_sys);
          rf_write_start = wr;
          rf_exec_done = !wr;
          @(negedge clk_sys) {rf_write_start, rf_exec_done} = 2'h0;
          // internal write lasts until the answer
          repeat (3) @(negedge clk_sys);
          rf_answer_start = wr;
          @(negedge clk_sys) rf_answer_start = 1'b0;
        end
        @(posedge clk_sys) rdr_busy = 1'b0;
      end
    end
  end
endmodule : tscr_rf_reader

//--- design/tscr_map.svh
// Register map, field positions and reset values for the tag system configuration block
// How it works
// - Sixteen-bit sector write-lock area sits at system byte 2048, guarding I2C writes only.
// - Lock bits 3..0 guard sectors 0..3; one blocks writes, zero allows, clearing needs the password like any lock write.
// - Lock area reads always allowed; lock writes need the I2C password presented.
// - Both lock bytes reset to zero, so every sector starts writable.
// - Config byte at 2320: bit3 pin mode, bit2 harvest default, bits1..0 sink level.
// - Control register at 2336: bit7 write done, bit1 field present, bit0 harvest enable.
// - Busy mode drives the activity pin low from RF start of frame to execution end.
// - Busy mode, bad RF command: pin low only from start of frame to CRC reception.
// - Losing the RF field releases a low-driven activity pin to high impedance.
// - Busy mode keeps the activity pin released while I2C commands execute.
// - Write-in-progress mode drives pin low from valid RF write end to answer start.
// - Write-in-progress mode keeps the pin released during I2C write operations.
// - Harvest output off when enable is zero; otherwise only while power and load allow.
// - Write-done flag clears at reset and write start, sets only on correct completion.
// - At power-up harvest enable loads the inverse of the stored harvest default bit.
// - Field-present flag reads one when RF power suffices for commands, else zero.
// - Control register read over RF returns field-present as one always.
// - I2C reads and writes of the config byte always allowed with system-area select.
// - RF commands: read whole config byte, write harvest bits only, write pin bit only.
// - Any config byte write takes effect at once, no power cycle needed.
// - Control register I2C access always allowed; RF reads it and sets or clears enable.
// - Control register read over RF returns write-done as zero and bits 6..2 zero.
`ifndef TSCR_MAP_SVH
`define TSCR_MAP_SVH

`define TSCR_ADDR_LOCK_LO   12'h800
`define TSCR_ADDR_LOCK_HI   12'h801
`define TSCR_ADDR_CONFIG    12'h910
`define TSCR_ADDR_CONTROL   12'h920

`define TSCR_LOCK_RESET     16'h0000
`define TSCR_CONFIG_RESET   8'hF4

`define TSCR_CFG_PIN_MODE   3
`define TSCR_CFG_HARV_OFF   2
`define TSCR_CFG_SINK_HI    1
`define TSCR_CFG_SINK_LO    0

`define TSCR_CTL_WR_DONE    7
`define TSCR_CTL_FIELD      1
`define TSCR_CTL_HARV_EN    0

`define TSCR_SECTOR_MSB     3
`define TSCR_UNMAPPED_DATA  8'h00

`endif

//--- design/tscr_pkg.sv
// Types shared by the tag system configuration block
package tscr_pkg;

  typedef enum logic [2:0] {
    TSCR_ACT_IDLE = 3'b001,
    TSCR_ACT_BUSY = 3'b010,
    TSCR_ACT_WIP  = 3'b100
  } tscr_act_t;

endpackage : tscr_pkg

//--- design/tscr_regs.sv
// System configuration registers and RF activity pin control of the tag memory
`timescale 1ns/10ps
`include "tscr_map.svh"
module tscr_regs
  import tscr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // I2C byte access from the protocol engine
  input  wire logic        i2c_rd,
  input  wire logic        i2c_wr,
  input  wire logic        system_area_select,
  input  wire logic [11:0] i2c_addr,
  input  wire logic [7:0]  i2c_wdata,
  input  wire logic        i2c_password_ok,
  output logic      [7:0]  i2c_rdata,
  output logic             i2c_rvalid,
  // I2C activity and write cycle
  input  wire logic        i2c_cmd_active,
  input  wire logic        i2c_write_active,
  input  wire logic        wr_cycle_start,
  input  wire logic        wr_cycle_ok,
  // Non-volatile load at power-up
  input  wire logic        nvm_load,
  input  wire logic [7:0]  nvm_config,
  // RF configuration commands
  input  wire logic        read_config_cmd,
  input  wire logic        write_harvest_cfg_cmd,
  input  wire logic        write_pin_cfg_cmd,
  input  wire logic        read_control_cmd,
  input  wire logic        set_harvest_enable_cmd,
  input  wire logic [7:0]  rf_wdata,
  output logic      [7:0]  rf_rdata,
  output logic             rf_rvalid,
  // RF frame events
  input  wire logic        rf_sof,
  input  wire logic        rf_crc_done,
  input  wire logic        rf_cmd_bad,
  input  wire logic        rf_exec_done,
  input  wire logic        rf_write_start,
  input  wire logic        rf_answer_start,
  // Analog status pins
  input  wire logic        field_on_pin,
  input  wire logic        harvest_power_ok_pin,
  input  wire logic        harvest_load_ok_pin,
  // Open-drain activity pin
  output logic             rf_activity_pin_o,
  output logic             rf_activity_pin_oe,
  // Harvest output and sector guard
  output logic             harvest_out_en,
  output logic      [3:0]  sector_write_lock,
  output logic      [7:0]  config_byte,
  output logic      [7:0]  control_byte
);

  logic [15:0] sector_write_lock_bits_r;
  logic [7:0]  nonvolatile_config_byte_r;
  logic        harvest_enable_r;
  logic        wr_done_r;
  logic [2:0]  pins_s;
  logic        field_on_s;
  logic        power_ok_s;
  logic        load_ok_s;
  tscr_act_t   act_r;
  tscr_act_t   act_nxt;
  logic        act_drive;
  logic        sel_lock_lo;
  logic        sel_lock_hi;
  logic        sel_config;
  logic        sel_control;
  logic [7:0]  ctl_i2c_view;
  logic [7:0]  ctl_rf_view;
  logic [7:0]  cfg_wr_data;
  logic        cfg_wr;

  // Named so the power-up enable can pick one bit out of the delivery value
  localparam logic [7:0] CFG_RESET = `TSCR_CONFIG_RESET;

  tscr_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .async_in ({field_on_pin, harvest_power_ok_pin, harvest_load_ok_pin}),
    .sync_out (pins_s)
  );

  assign field_on_s = pins_s[2];
  assign power_ok_s = pins_s[1];
  assign load_ok_s  = pins_s[0];

  // the select bit is required for every system-area hit
  assign sel_lock_lo = system_area_select && (i2c_addr == `TSCR_ADDR_LOCK_LO);
  assign sel_lock_hi = system_area_select && (i2c_addr == `TSCR_ADDR_LOCK_HI);
  assign sel_config  = system_area_select && (i2c_addr == `TSCR_ADDR_CONFIG);
  assign sel_control = system_area_select && (i2c_addr == `TSCR_ADDR_CONTROL);

  // control register as seen from I2C
  always_comb
  begin
    ctl_i2c_view                     = '0;
    ctl_i2c_view[`TSCR_CTL_WR_DONE]  = wr_done_r;
    ctl_i2c_view[`TSCR_CTL_FIELD]    = field_on_s;
    ctl_i2c_view[`TSCR_CTL_HARV_EN]  = harvest_enable_r;
  end

  // RF view forces field present, hides write done
  always_comb
  begin
    ctl_rf_view                     = '0;
    ctl_rf_view[`TSCR_CTL_FIELD]    = 1'b1;
    ctl_rf_view[`TSCR_CTL_HARV_EN]  = harvest_enable_r;
  end

  // lock area, reset to all writable
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sector_write_lock_bits_r <= `TSCR_LOCK_RESET;
    end
    else if (i2c_wr && i2c_password_ok)
    begin
      // writes without the password never reach here
      if (sel_lock_lo)
      begin
        sector_write_lock_bits_r[7:0] <= i2c_wdata;
      end
      if (sel_lock_hi)
      begin
        sector_write_lock_bits_r[15:8] <= i2c_wdata;
      end
    end
  end

  always_comb
  begin
    cfg_wr      = 1'b0;
    cfg_wr_data = nonvolatile_config_byte_r;
    if (write_harvest_cfg_cmd)
    begin
      cfg_wr                          = 1'b1;
      cfg_wr_data[`TSCR_CFG_HARV_OFF] = rf_wdata[`TSCR_CFG_HARV_OFF];
      cfg_wr_data[`TSCR_CFG_SINK_HI]  = rf_wdata[`TSCR_CFG_SINK_HI];
      cfg_wr_data[`TSCR_CFG_SINK_LO]  = rf_wdata[`TSCR_CFG_SINK_LO];
    end
    if (write_pin_cfg_cmd)
    begin
      cfg_wr                          = 1'b1;
      cfg_wr_data[`TSCR_CFG_PIN_MODE] = rf_wdata[`TSCR_CFG_PIN_MODE];
    end
    // I2C is exclusive of RF; taking it last gives it the final word
    if (i2c_wr && sel_config)
    begin
      cfg_wr      = 1'b1;
      cfg_wr_data = i2c_wdata;
    end
  end

  // config byte, applied at once to the pin logic
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      nonvolatile_config_byte_r <= `TSCR_CONFIG_RESET;
    end
    else if (nvm_load)
    begin
      nonvolatile_config_byte_r <= nvm_config;
    end
    else if (cfg_wr)
    begin
      nonvolatile_config_byte_r <= cfg_wr_data;
    end
  end

  // harvest enable: power-up default then software
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      harvest_enable_r <= ~CFG_RESET[`TSCR_CFG_HARV_OFF];
    end
    else if (nvm_load)
    begin
      harvest_enable_r <= ~nvm_config[`TSCR_CFG_HARV_OFF];
    end
    else if (i2c_wr && sel_control)
    begin
      harvest_enable_r <= i2c_wdata[`TSCR_CTL_HARV_EN];
    end
    else if (set_harvest_enable_cmd)
    begin
      harvest_enable_r <= rf_wdata[`TSCR_CTL_HARV_EN];
    end
  end

  // write-done flag, completion wins over a same-cycle start
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_done_r <= 1'b0;
    end
    else if (wr_cycle_ok)
    begin
      wr_done_r <= 1'b1;
    end
    else if (wr_cycle_start)
    begin
      wr_done_r <= 1'b0;
    end
  end

  // I2C read path, unmapped bytes read zero
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      i2c_rdata  <= `TSCR_UNMAPPED_DATA;
      i2c_rvalid <= 1'b0;
    end
    else
    begin
      i2c_rvalid <= i2c_rd;
      if (i2c_rd)
      begin
        if (sel_lock_lo)
        begin
          i2c_rdata <= sector_write_lock_bits_r[7:0];
        end
        else if (sel_lock_hi)
        begin
          i2c_rdata <= sector_write_lock_bits_r[15:8];
        end
        else if (sel_config)
        begin
          i2c_rdata <= nonvolatile_config_byte_r;
        end
        else if (sel_control)
        begin
          i2c_rdata <= ctl_i2c_view;
        end
        else
        begin
          i2c_rdata <= `TSCR_UNMAPPED_DATA;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rf_rdata  <= '0;
      rf_rvalid <= 1'b0;
    end
    else
    begin
      rf_rvalid <= read_config_cmd || read_control_cmd;
      if (read_config_cmd)
      begin
        rf_rdata <= nonvolatile_config_byte_r;
      end
      else if (read_control_cmd)
      begin
        rf_rdata <= ctl_rf_view;
      end
    end
  end

  always_comb
  begin
    act_nxt = act_r;
    unique case (act_r)
      TSCR_ACT_IDLE:
      begin
        if (rf_sof)
        begin
          act_nxt = TSCR_ACT_BUSY;
        end
        else if (rf_write_start)
        begin
          act_nxt = TSCR_ACT_WIP;
        end
      end
      TSCR_ACT_BUSY:
      begin
        if (rf_crc_done && rf_cmd_bad)
        begin
          act_nxt = TSCR_ACT_IDLE;
        end
        else if (rf_exec_done)
        begin
          act_nxt = TSCR_ACT_IDLE;
        end
        else if (rf_write_start)
        begin
          act_nxt = TSCR_ACT_WIP;
        end
      end
      TSCR_ACT_WIP:
      begin
        if (rf_answer_start || rf_exec_done)
        begin
          act_nxt = TSCR_ACT_IDLE;
        end
      end
    endcase
    if (!field_on_s)
    begin
      act_nxt = TSCR_ACT_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      act_r <= TSCR_ACT_IDLE;
    end
    else
    begin
      act_r <= act_nxt;
    end
  end

  // Mode read live from the config byte so a rewrite acts at once
  always_comb
  begin
    if (nonvolatile_config_byte_r[`TSCR_CFG_PIN_MODE])
    begin
      // write-in-progress window, released during I2C writes
      act_drive = (act_nxt == TSCR_ACT_WIP) && !i2c_write_active;
    end
    else
    begin
      // whole command window, released during I2C commands
      act_drive = (act_nxt != TSCR_ACT_IDLE) && !i2c_cmd_active;
    end
  end

  // Open drain: only ever drives low
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rf_activity_pin_o  <= 1'b0;
      rf_activity_pin_oe <= 1'b0;
    end
    else
    begin
      rf_activity_pin_o  <= 1'b0;
      rf_activity_pin_oe <= act_drive;
    end
  end

  // harvest gated by enable, power and load
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      harvest_out_en <= 1'b0;
    end
    else
    begin
      harvest_out_en <= harvest_enable_r && power_ok_s && load_ok_s;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      sector_write_lock <= '0;
      config_byte       <= `TSCR_CONFIG_RESET;
      control_byte      <= '0;
    end
    else
    begin
      sector_write_lock <= sector_write_lock_bits_r[`TSCR_SECTOR_MSB:0];
      config_byte       <= nonvolatile_config_byte_r;
      control_byte      <= ctl_i2c_view;
    end
  end

endmodule : tscr_regs

//--- design/tscr_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module tscr_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : tscr_sync
